// >>> rtl/sprc_pkg.sv
// Purpose: Shared constants for the single-pair PMA/PMD management registers.
// Assumes: APB word access; register index times four is the byte address.
// Notes: Indices are kept as printed; the decoder scales them.
package sprc_pkg;
   localparam int unsigned SPRC_IDX_W = 14;
   localparam int unsigned SPRC_REG_W = 16;
   localparam logic [SPRC_IDX_W-1:0] SPRC_IDX_ABILITY = 14'h0012;
   localparam logic [SPRC_IDX_W-1:0] SPRC_IDX_CONTROL = 14'h0834;
   localparam logic [SPRC_IDX_W-1:0] SPRC_IDX_PMA_CTRL = 14'h08F6;
   localparam logic [SPRC_IDX_W-1:0] SPRC_IDX_PMA_STAT = 14'h08F7;
   // Ability word: only long reach is reported
   localparam logic [SPRC_REG_W-1:0] SPRC_ABILITY_VAL = 16'h0004;
   // Control word
   localparam int unsigned SPRC_CTL_RSVD_ONE = 15;
   localparam int unsigned SPRC_CTL_MASTER = 14;
   localparam int unsigned SPRC_CTL_TYPE_LSB = 0;
   localparam int unsigned SPRC_TYPE_W = 4;
   localparam logic [SPRC_REG_W-1:0] SPRC_CONTROL_RST = 16'h8002;
   localparam logic [SPRC_TYPE_W-1:0] SPRC_TYPE_RST = 4'h2;
   // PMA control word
   localparam int unsigned SPRC_PMA_SELFCLR = 15;
   localparam int unsigned SPRC_PMA_TX_OFF = 14;
   localparam int unsigned SPRC_PMA_HI_SWING = 12;
   localparam int unsigned SPRC_PMA_SPARE = 11;
   localparam int unsigned SPRC_PMA_EEE = 10;
   localparam int unsigned SPRC_PMA_LOOPBACK = 0;
   localparam logic [SPRC_REG_W-1:0] SPRC_PMA_CTRL_RST = 16'h0000;
   // PMA status word: capability bit only
   localparam int unsigned SPRC_STAT_HI_CAP = 12;
   typedef enum logic [SPRC_TYPE_W-1:0] {
      SPRC_TYPE_FAST = 4'b0000,
      SPRC_TYPE_GIGABIT = 4'b0001,
      SPRC_TYPE_LONG = 4'b0010,
      SPRC_TYPE_SHORT = 4'b0011
   } sprc_type_t;
endpackage

// >>> rtl/sprc_regs.sv
// Purpose: APB register bank steering role, PHY type, amplitude, tx-off,
//    EEE and loopback of a single-pair long-reach PMA/PMD.
// Assumes: Zero-wait APB slave; straps stable around reset release.
// Notes: Mode outputs lag their cause by one clock.
//    The type field stores any code; reserved codes are flagged, not refused.
//    Strap levels are taken at the first edge after reset release.
//
// The implementer's own choice: the APB register port.
`timescale 1ns/1ns
module sprc_regs
   import sprc_pkg::*;
#(
   parameter int unsigned ADDR_W = 16
) (
   input wire logic i_mclk,
   input wire logic i_rst_n,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [ADDR_W-1:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   input wire logic i_strap_master,
   input wire logic i_strap_high_swing,
   input wire logic i_high_swing_capable,
   input wire logic i_aneg_enable,
   input wire logic i_forced_cfg_enable,
   input wire logic i_aneg_master,
   input wire logic i_aneg_high_swing,
   input wire logic [3:0] i_aneg_phy_type,
   output logic o_master_mode,
   output logic o_high_swing_mode,
   output logic [3:0] o_phy_type,
   output logic o_phy_type_reserved,
   output logic o_tx_output_off,
   output logic o_energy_efficient_enable,
   output logic o_local_loopback_enable
);
   if (ADDR_W < SPRC_IDX_W + 2) begin : g_bad_addr
      $error("ADDR_W too narrow for the register map");
   end
   if (ADDR_W > 32) begin : g_wide_addr
      $error("ADDR_W wider than the APB address");
   end

   logic [SPRC_IDX_W-1:0] idx;
   logic aligned;
   logic setup;
   logic wr_access;
   logic hit;
   logic [SPRC_REG_W-1:0] rd_word;
   logic strap_done_ff;
   logic master_select_ff;
   logic [SPRC_TYPE_W-1:0] phy_type_select_ff;
   logic tx_output_off_ff;
   logic high_swing_select_ff;
   logic spare_ff;
   logic self_clear_ff;
   logic energy_efficient_enable_ff;
   logic local_loopback_enable_ff;
   logic [31:0] prdata_ff;
   logic pslverr_ff;
   logic master_mode_ff;
   logic high_swing_mode_ff;
   logic [SPRC_TYPE_W-1:0] phy_type_ff;
   logic nxt_master_mode;
   logic nxt_high_swing_mode;
   logic [SPRC_TYPE_W-1:0] nxt_phy_type;
   logic [SPRC_REG_W-1:0] control_word;
   logic [SPRC_REG_W-1:0] pma_word;
   logic [SPRC_REG_W-1:0] stat_word;

   assign idx = i_paddr[SPRC_IDX_W+1:2];
   // A shift rather than a part-select, so ADDR_W may equal the index span
   assign aligned = (i_paddr[1:0] == 2'h0) && ((i_paddr >> (SPRC_IDX_W + 2)) == '0);
   assign setup = i_psel && !i_penable;
   // Zero-wait slave: every access phase completes at once
   assign o_pready = 1'b1;
   assign wr_access = i_psel && i_penable && i_pwrite && !pslverr_ff;
   assign hit = aligned && (idx == SPRC_IDX_ABILITY || idx == SPRC_IDX_CONTROL ||
                            idx == SPRC_IDX_PMA_CTRL || idx == SPRC_IDX_PMA_STAT);

   always_comb begin
      control_word = '0;
      control_word[SPRC_CTL_RSVD_ONE] = 1'b1;
      control_word[SPRC_CTL_MASTER] = master_select_ff;
      control_word[SPRC_CTL_TYPE_LSB +: SPRC_TYPE_W] = phy_type_select_ff;
      pma_word = '0;
      pma_word[SPRC_PMA_SELFCLR] = self_clear_ff;
      pma_word[SPRC_PMA_TX_OFF] = tx_output_off_ff;
      pma_word[SPRC_PMA_HI_SWING] = high_swing_select_ff;
      pma_word[SPRC_PMA_SPARE] = spare_ff;
      pma_word[SPRC_PMA_EEE] = energy_efficient_enable_ff;
      pma_word[SPRC_PMA_LOOPBACK] = local_loopback_enable_ff;
      stat_word = '0;
      stat_word[SPRC_STAT_HI_CAP] = i_high_swing_capable;
   end

   always_comb begin
      rd_word = '0;
      case (idx)
         SPRC_IDX_ABILITY: begin
            rd_word = SPRC_ABILITY_VAL;
         end
         SPRC_IDX_CONTROL: begin
            rd_word = control_word;
         end
         SPRC_IDX_PMA_CTRL: begin
            rd_word = pma_word;
         end
         SPRC_IDX_PMA_STAT: begin
            rd_word = stat_word;
         end
         default: begin
            rd_word = '0;
         end
      endcase
   end

   // Read data and error are captured in setup; o_prdata stays registered, o_pslverr is gated by psel and penable
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         prdata_ff <= 32'h0000_0000;
         pslverr_ff <= 1'b0;
      end else if (setup) begin
         prdata_ff <= (hit && !i_pwrite) ? {16'h0000, rd_word} : 32'h0000_0000;
         pslverr_ff <= !hit;
      end
   end
   assign o_prdata = prdata_ff;
   assign o_pslverr = pslverr_ff && i_psel && i_penable;

   // Straps are taken on the first edge after release, not under reset
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         strap_done_ff <= 1'b0;
      end else begin
         strap_done_ff <= 1'b1;
      end
   end

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         master_select_ff <= 1'b0;
         phy_type_select_ff <= SPRC_TYPE_RST;
      end else if (!strap_done_ff) begin
         master_select_ff <= i_strap_master;
      end else if (wr_access && idx == SPRC_IDX_CONTROL) begin
         // Bit 15 and 13:4 have no storage
         master_select_ff <= i_pwdata[SPRC_CTL_MASTER];
         phy_type_select_ff <= i_pwdata[SPRC_CTL_TYPE_LSB +: SPRC_TYPE_W];
      end
   end

   // Ability index owns no storage, so writes there fall through
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         tx_output_off_ff <= SPRC_PMA_CTRL_RST[SPRC_PMA_TX_OFF];
         high_swing_select_ff <= SPRC_PMA_CTRL_RST[SPRC_PMA_HI_SWING];
         spare_ff <= SPRC_PMA_CTRL_RST[SPRC_PMA_SPARE];
         energy_efficient_enable_ff <= SPRC_PMA_CTRL_RST[SPRC_PMA_EEE];
         local_loopback_enable_ff <= SPRC_PMA_CTRL_RST[SPRC_PMA_LOOPBACK];
      end else if (!strap_done_ff) begin
         high_swing_select_ff <= i_strap_high_swing;
      end else if (wr_access && idx == SPRC_IDX_PMA_CTRL) begin
         tx_output_off_ff <= i_pwdata[SPRC_PMA_TX_OFF];
         high_swing_select_ff <= i_pwdata[SPRC_PMA_HI_SWING];
         spare_ff <= i_pwdata[SPRC_PMA_SPARE];
         energy_efficient_enable_ff <= i_pwdata[SPRC_PMA_EEE];
         local_loopback_enable_ff <= i_pwdata[SPRC_PMA_LOOPBACK];
      end
   end

   // Reserved self-clearing bit drops one cycle after it is written
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         self_clear_ff <= SPRC_PMA_CTRL_RST[SPRC_PMA_SELFCLR];
      end else if (strap_done_ff && wr_access && idx == SPRC_IDX_PMA_CTRL) begin
         self_clear_ff <= i_pwdata[SPRC_PMA_SELFCLR];
      end else begin
         self_clear_ff <= 1'b0;
      end
   end

   // Effective operating modes
   always_comb begin
      nxt_master_mode = i_aneg_enable ? i_aneg_master : master_select_ff;
      // Capability pin caps the swing even if software asked for high
      nxt_high_swing_mode = (i_aneg_enable ? i_aneg_high_swing : high_swing_select_ff)
                            && i_high_swing_capable;
      nxt_phy_type = (!i_aneg_enable && i_forced_cfg_enable) ?
                     phy_type_select_ff : i_aneg_phy_type;
   end

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         master_mode_ff <= 1'b0;
      end else begin
         master_mode_ff <= nxt_master_mode;
      end
   end

   // Registered so the analog side never sees a glitch from the pin gate
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         high_swing_mode_ff <= 1'b0;
      end else begin
         high_swing_mode_ff <= nxt_high_swing_mode;
      end
   end

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         phy_type_ff <= SPRC_TYPE_RST;
      end else begin
         phy_type_ff <= nxt_phy_type;
      end
   end

   assign o_master_mode = master_mode_ff;
   assign o_high_swing_mode = high_swing_mode_ff;
   assign o_phy_type = phy_type_ff;
   // Only 00XX codes name a type; 1XXX and 01XX are reserved
   always_comb begin
      case (sprc_type_t'(phy_type_ff))
         SPRC_TYPE_FAST, SPRC_TYPE_GIGABIT, SPRC_TYPE_LONG, SPRC_TYPE_SHORT: begin
            o_phy_type_reserved = 1'b0;
         end
         default: begin
            o_phy_type_reserved = 1'b1;
         end
      endcase
   end
   assign o_tx_output_off = tx_output_off_ff;
   assign o_energy_efficient_enable = energy_efficient_enable_ff;
   assign o_local_loopback_enable = local_loopback_enable_ff;

   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (!i_rst_n);

   logic rd_ability;
   logic rd_control;
   assign rd_ability = setup && !i_pwrite && aligned && idx == SPRC_IDX_ABILITY;
   assign rd_control = setup && !i_pwrite && aligned && idx == SPRC_IDX_CONTROL;

   ability_ro_a: assert property (rd_ability ##1 (i_psel && i_penable) |->
      o_prdata == 32'h0000_0004 && !o_pslverr)
      else $error("ability read returned wrong word");
   abil_short_a: assert property (rd_ability |=> !o_prdata[3])
      else $error("short reach ability not zero");
   abil_long_a: assert property (rd_ability |=> o_prdata[2])
      else $error("long reach ability not one");
   abil_zero_a: assert property (rd_ability |=> o_prdata[1:0] == 2'h0
      && o_prdata[15:4] == 12'h000)
      else $error("unsupported ability bits not zero");
   role_forced_a: assert property (!i_aneg_enable |=>
      o_master_mode == $past(master_select_ff))
      else $error("forced role does not follow master select");
   role_aneg_a: assert property (i_aneg_enable |=>
      o_master_mode == $past(i_aneg_master))
      else $error("negotiated role not applied");
   type_sel_a: assert property ((!i_aneg_enable && i_forced_cfg_enable) |=>
      o_phy_type == $past(phy_type_select_ff))
      else $error("forced PHY type not applied");
   type_rsvd_a: assert property (o_phy_type[3] || o_phy_type[2] |-> o_phy_type_reserved)
      else $error("reserved PHY type not flagged");
   ctrl_top_a: assert property (rd_control |=> o_prdata[15])
      else $error("control bit 15 not one");
   tx_off_a: assert property (strap_done_ff && wr_access && idx == SPRC_IDX_PMA_CTRL |=>
      o_tx_output_off == $past(i_pwdata[SPRC_PMA_TX_OFF]))
      else $error("transmit disable not applied");
   swing_sel_a: assert property (!i_aneg_enable && i_high_swing_capable |=>
      o_high_swing_mode == $past(high_swing_select_ff))
      else $error("forced amplitude not applied");
   swing_aneg_a: assert property (i_aneg_enable && i_high_swing_capable |=>
      o_high_swing_mode == $past(i_aneg_high_swing))
      else $error("negotiated amplitude not applied");
   loop_en_a: assert property (strap_done_ff && wr_access && idx == SPRC_IDX_PMA_CTRL |=>
      o_local_loopback_enable == $past(i_pwdata[SPRC_PMA_LOOPBACK]))
      else $error("loopback enable not applied");
   swing_cap_a: assert property (o_high_swing_mode |-> $past(i_high_swing_capable))
      else $error("high swing without capability");
   strap_load_a: assert property ($rose(strap_done_ff) |->
      master_select_ff == $past(i_strap_master)
      && high_swing_select_ff == $past(i_strap_high_swing))
      else $error("strap levels not loaded");
   strap_wins_a: assert property (!strap_done_ff |=>
      $stable(phy_type_select_ff) && $stable(tx_output_off_ff))
      else $error("write taken in the strap cycle");

   // Register-file, bus and mode-output checks
   rsvd_zero_a: assert property (rd_control |=> o_prdata[13:4] == 10'h000
      && o_prdata[31:16] == 16'h0000)
      else $error("control reserved bits not zero");
   ctrl_write_a: assert property (strap_done_ff && wr_access && idx == SPRC_IDX_CONTROL |=>
      master_select_ff == $past(i_pwdata[SPRC_CTL_MASTER])
      && phy_type_select_ff == $past(i_pwdata[SPRC_CTL_TYPE_LSB +: SPRC_TYPE_W]))
      else $error("control write not stored");
   abil_write_a: assert property (wr_access && idx == SPRC_IDX_ABILITY |=>
      $stable(control_word) && $stable(pma_word))
      else $error("ability write disturbed a register");
   type_aneg_a: assert property (i_aneg_enable |=>
      o_phy_type == $past(i_aneg_phy_type))
      else $error("negotiated PHY type not applied");
   swing_off_a: assert property (!i_high_swing_capable |=> !o_high_swing_mode)
      else $error("high swing while not capable");
   hs_write_a: assert property (strap_done_ff && wr_access && idx == SPRC_IDX_PMA_CTRL |=>
      high_swing_select_ff == $past(i_pwdata[SPRC_PMA_HI_SWING]))
      else $error("amplitude select not stored");
   eee_write_a: assert property (strap_done_ff && wr_access && idx == SPRC_IDX_PMA_CTRL |=>
      o_energy_efficient_enable == $past(i_pwdata[SPRC_PMA_EEE]))
      else $error("energy efficient enable not stored");
   selfclr_a: assert property (self_clear_ff && !(wr_access && idx == SPRC_IDX_PMA_CTRL) |=>
      !self_clear_ff)
      else $error("self-clearing bit did not drop");
   unmapped_a: assert property (setup && !hit ##1 (i_psel && i_penable) |->
      o_pslverr)
      else $error("unmapped access not refused");
   prdata_hold_a: assert property (!setup |=> $stable(o_prdata))
      else $error("read data moved outside setup");

   write_ctrl_c: cover property (wr_access && idx == SPRC_IDX_CONTROL);
   aneg_master_c: cover property (i_aneg_enable && o_master_mode);
   loop_on_c: cover property (o_local_loopback_enable && o_tx_output_off);
   unmapped_c: cover property (o_pslverr);
   rsvd_type_c: cover property (o_phy_type_reserved);
endmodule

// >>> sim/base_t1_pma_control_regs_tb.sv
// Purpose: Self-checking bench for the single-pair PMA/PMD register bank.
// Assumes: Zero-wait APB slave; byte address is four times the register index.
// Notes: Read results are queued by the driver and compared by a monitor.
`timescale 1ns/1ns
module base_t1_pma_control_regs_tb;
   import sprc_pkg::*;
   localparam logic [15:0] A_ABL = {SPRC_IDX_ABILITY, 2'b00};
   localparam logic [15:0] A_CTL = {SPRC_IDX_CONTROL, 2'b00};
   localparam logic [15:0] A_PMA = {SPRC_IDX_PMA_CTRL, 2'b00};
   localparam logic [15:0] A_STA = {SPRC_IDX_PMA_STAT, 2'b00};
   logic i_mclk = 1'b0;
   logic i_rst_n = 1'b0;
   logic i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
   logic [15:0] i_paddr = 16'h0000;
   logic [31:0] i_pwdata = 32'h0000_0000;
   logic i_strap_master = 1'b1, i_strap_high_swing = 1'b1, i_high_swing_capable = 1'b1;
   logic i_aneg_enable = 1'b0, i_forced_cfg_enable = 1'b1;
   logic i_aneg_master = 1'b0, i_aneg_high_swing = 1'b0;
   logic [3:0] i_aneg_phy_type = 4'h0;
   logic [31:0] o_prdata;
   logic o_pready, o_pslverr, o_master_mode, o_high_swing_mode, o_phy_type_reserved;
   logic [3:0] o_phy_type;
   logic o_tx_output_off, o_energy_efficient_enable, o_local_loopback_enable;
   int fail_count = 0;
   int comparisons = 0;
   int cycles = 0;
   logic [32:0] notes[$];
   logic [31:0] rnd = 32'hC1A1EFD9;
   logic [15:0] d;

   always #2 i_mclk = ~i_mclk;

   sprc_regs #(.ADDR_W(16)) i_sprc_regs (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_psel(i_psel),
      .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
      .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
      .i_strap_master(i_strap_master), .i_strap_high_swing(i_strap_high_swing),
      .i_high_swing_capable(i_high_swing_capable), .i_aneg_enable(i_aneg_enable),
      .i_forced_cfg_enable(i_forced_cfg_enable), .i_aneg_master(i_aneg_master),
      .i_aneg_high_swing(i_aneg_high_swing), .i_aneg_phy_type(i_aneg_phy_type),
      .o_master_mode(o_master_mode), .o_high_swing_mode(o_high_swing_mode),
      .o_phy_type(o_phy_type), .o_phy_type_reserved(o_phy_type_reserved),
      .o_tx_output_off(o_tx_output_off),
      .o_energy_efficient_enable(o_energy_efficient_enable),
      .o_local_loopback_enable(o_local_loopback_enable));

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic finish_test;
      if (fail_count == 0 && comparisons > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // Holds the request until pready is seen high, then releases it
   task automatic apb(input logic wr, input logic [15:0] a, input logic [15:0] wd,
                      input logic [15:0] e, input logic err);
      @(posedge i_mclk);
      i_psel <= 1'b1;
      i_penable <= 1'b0;
      i_pwrite <= wr;
      i_paddr <= a;
      i_pwdata <= {rnd[31:16], wd};
      notes.push_back({err, 16'h0000, e});
      @(posedge i_mclk);
      i_penable <= 1'b1;
      do begin
         @(posedge i_mclk);
      end while (o_pready !== 1'b1);
      i_psel <= 1'b0;
      i_penable <= 1'b0;
   endtask

   // Mode outputs lag their cause, so let three edges pass first
   task automatic mode(input logic [9:0] e);
      repeat (3) @(posedge i_mclk);
      @(negedge i_mclk);
      chk({22'h0, o_master_mode, o_high_swing_mode, o_tx_output_off, o_energy_efficient_enable,
           o_local_loopback_enable, o_phy_type_reserved, o_phy_type}, {22'h0, e});
      // Return on a rising edge so the caller drives on it
      @(posedge i_mclk);
   endtask

   always @(posedge i_mclk) begin
      logic [32:0] note;
      if (i_psel && i_penable && o_pready === 1'b1 && notes.size() > 0) begin
         note = notes.pop_front();
         chk({31'h0, o_pslverr}, {31'h0, note[32]});
         if (!i_pwrite) begin
            chk(o_prdata, note[31:0]);
         end
      end
   end

   always @(posedge i_mclk) begin
      cycles <= cycles + 1;
      if (cycles == 6000) begin
         fail_count++;
         finish_test();
      end
   end

   initial begin
      repeat (12) @(posedge i_mclk);
      i_rst_n <= 1'b1;
      apb(1'b0, A_ABL, 16'h0000, 16'h0004, 1'b0);
      apb(1'b0, A_CTL, 16'h0000, 16'hC002, 1'b0);
      apb(1'b0, A_PMA, 16'h0000, 16'h1000, 1'b0);
      apb(1'b0, A_STA, 16'h0000, 16'h1000, 1'b0);
      mode({2'b11, 3'b000, 1'b0, 4'h2});
      apb(1'b1, A_ABL, 16'hFFFF, 16'h0000, 1'b0);
      apb(1'b0, A_ABL, 16'h0000, 16'h0004, 1'b0);
      for (int c = 0; c < 16; c++) begin
         rnd = lfsr(rnd);
         apb(1'b1, A_CTL, {rnd[10], c[0], rnd[9:0], SPRC_TYPE_LONG}, 16'h0000, 1'b0);
         apb(1'b0, A_CTL, 16'h0000, {1'b1, c[0], 10'h000, SPRC_TYPE_LONG}, 1'b0);
         mode({c[0], 1'b1, 3'b000, 1'b0, SPRC_TYPE_LONG});
      end
      // Every type code arrives from negotiation, so the type output walks all sixteen codes and reserved ones get flagged
      for (int k = 0; k < 16; k++) begin
         rnd = lfsr(rnd);
         i_aneg_enable <= 1'b1;
         i_aneg_master <= rnd[0];
         i_aneg_high_swing <= rnd[1];
         i_aneg_phy_type <= k[3:0];
         mode({rnd[0], rnd[1], 3'b000, k[3] | k[2], k[3:0]});
      end
      i_aneg_enable <= 1'b0;
      i_forced_cfg_enable <= 1'b0;
      mode({2'b11, 3'b000, 1'b1, 4'hF});
      for (int k = 0; k < 3; k++) begin
         rnd = lfsr(rnd);
         d = (k == 0) ? 16'hFFFF : (k == 1) ? 16'h0000 : (rnd[15:0] | 16'h8000);
         apb(1'b1, A_PMA, d, 16'h0000, 1'b0);
         repeat (2) @(posedge i_mclk);
         apb(1'b0, A_PMA, 16'h0000, d & 16'h5C01, 1'b0);
         mode({1'b1, d[12], d[14], d[10], d[0], 1'b1, 4'hF});
      end
      i_high_swing_capable <= 1'b0;
      apb(1'b0, A_STA, 16'h0000, 16'h0000, 1'b0);
      mode({1'b1, 1'b0, d[14], d[10], d[0], 1'b1, 4'hF});
      apb(1'b0, 16'h0100, 16'h0000, 16'h0000, 1'b1);
      apb(1'b1, A_CTL + 16'h0001, 16'h0000, 16'h0000, 1'b1);
      apb(1'b0, A_CTL, 16'h0000, 16'hC002, 1'b0);
      // Second reset with both straps low
      @(posedge i_mclk);
      i_strap_master <= 1'b0;
      i_strap_high_swing <= 1'b0;
      i_rst_n <= 1'b0;
      repeat (3) @(posedge i_mclk);
      i_rst_n <= 1'b1;
      apb(1'b0, A_CTL, 16'h0000, 16'h8002, 1'b0);
      apb(1'b0, A_PMA, 16'h0000, 16'h0000, 1'b0);
      mode({2'b00, 3'b000, 1'b1, 4'hF});
      finish_test();
   end
endmodule
